// *** rtl/bit_flags.sv ***
// Purpose: builds operation fault and item error words per output message
// Assumes: fault inputs are asynchronous levels or pulses from other logic
// Notes: words refresh on every message strobe; nothing is latched across
//
// Contract
// - operation fault bits rebuilt each message, never latched
// - bit 0 set when regulator voltage out of range
// - slot overrun lengthens slot and sets bit 1
// - while slot extended, messages go out at reduced rate
// - bit 2 set when previous message missed due to busy transmitter
// - bit 3 set on internal peripheral access timeout
// - bit 4 set when any combined-sensor runtime fault flag set
// - clamp rate to 305 deg/s, acceleration 10.01 g; set bit 5
// - bit 6 on implausible accelerometer against its redundant partner
// - peripheral, sensor, clamp, plausibility faults mark affected items
// - error bits 0..13 flag message items 2..15
// - error bit 14 flags item 16, bit 15 flags item 17
// - operation fault word sent as one 16-bit item
`timescale 1ns/1ps
module bit_flags
   import bit_flags_pkg::*;
#(
   parameter int PLAUS_TOL = 200,
   parameter int P_NORMAL = PERIOD_NORMAL,
   parameter int P_EXT = PERIOD_EXTENDED
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // fault sources (asynchronous)
   input wire logic i_reg_out_of_range,
   input wire logic i_slot_overrun,
   input wire logic i_periph_timeout,
   input wire logic [15:0] i_periph_items,
   input wire logic [31:0] i_combo_sensor_runtime_fault [3],
   input wire logic [15:0] i_combo_items,
   // transmitter state (same clock)
   input wire logic i_tx_busy,
   // samples (same clock)
   input wire logic signed [SAMPLE_W-1:0] i_samp [6],
   input wire logic signed [SAMPLE_W-1:0] i_acc_b [3],
   // message outputs
   output logic o_msg_strobe,
   output logic [WORD_W-1:0] o_op_fault,
   output logic [WORD_W-1:0] o_item_error,
   output logic o_slot_extended,
   output logic signed [SAMPLE_W-1:0] o_clamped [6]
);
   fault_collect_if flt ();
   logic signed [SAMPLE_W-1:0] clamped_c [6];

   sample_checker #(.PLAUS_TOL(PLAUS_TOL)) u_chk (
      .i_samp(i_samp),
      .i_acc_b(i_acc_b),
      .o_clamped(clamped_c),
      .flt(flt)
   );

   // two-flop synchronisers for the asynchronous fault levels
   logic [2:0] s1_r, s2_r, s1_nxt;
   logic [95:0] c1_r, c2_r;
   always_comb begin
      s1_nxt = {i_reg_out_of_range, i_slot_overrun, i_periph_timeout};
   end
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
         c1_r <= '0;
         c2_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s1_r;
         c1_r <= {i_combo_sensor_runtime_fault[2], i_combo_sensor_runtime_fault[1],
            i_combo_sensor_runtime_fault[0]};
         c2_r <= c1_r;
      end
   end
   logic reg_bad, ovr, ptmo;
   assign reg_bad = s2_r[2];
   assign ovr = s2_r[1];
   assign ptmo = s2_r[0];

   // item masks take the same two-flop path as the flags that qualify them,
   // so mask and flag line up; masks must be held steady while flagged
   logic [15:0] p1_r, k1_r, pitems_r, citems_r;
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         p1_r <= 16'h0000;
         k1_r <= 16'h0000;
         pitems_r <= 16'h0000;
         citems_r <= 16'h0000;
      end else begin
         p1_r <= i_periph_items;
         k1_r <= i_combo_items;
         pitems_r <= p1_r;
         citems_r <= k1_r;
      end
   end

   // period accumulators: gather faults seen since the last period end
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic ext_r, ext_nxt, strobe_nxt;
   logic [6:0] acc_r, acc_nxt, word_bits;
   logic [15:0] iacc_r, iacc_nxt, item_bits;
   logic missed_r, missed_nxt;
   logic [WORD_W-1:0] op_nxt, ie_nxt;

   always_comb begin
      word_bits = 7'h00;
      word_bits[OF_REG_RANGE] = reg_bad;
      word_bits[OF_SLOT_EXT] = ovr;
      word_bits[OF_PERIPH_TMO] = ptmo;
      word_bits[OF_COMBO_FAULT] = |c2_r;
      word_bits[OF_CLAMPED] = flt.any_clamp;
      word_bits[OF_IMPLAUSIBLE] = flt.any_implaus;
      item_bits = (ptmo ? pitems_r : 16'h0000) | ((|c2_r) ? citems_r : 16'h0000)
         | flt.clamp_mask | flt.implaus_mask;
   end

   // message pacing: the slot lengthens while overrun is seen
   always_comb begin
      ext_nxt = ext_r;
      cnt_nxt = cnt_r + CNT_W'(1);
      strobe_nxt = 1'b0;
      acc_nxt = acc_r | word_bits;
      iacc_nxt = iacc_r | item_bits;
      missed_nxt = missed_r;
      op_nxt = o_op_fault;
      ie_nxt = o_item_error;
      if (ovr) begin
         ext_nxt = 1'b1;
      end
      if (cnt_r >= CNT_W'((ext_r ? P_EXT : P_NORMAL) - 1)) begin
         cnt_nxt = '0;
         strobe_nxt = 1'b1;
         ext_nxt = ovr;
         if (i_tx_busy) begin
            // message dropped; report it in the next one sent
            missed_nxt = 1'b1;
         end else begin
            op_nxt = {9'h000, acc_nxt};
            op_nxt[OF_MSG_MISSED] = missed_r;
            ie_nxt = iacc_nxt;
            missed_nxt = 1'b0;
         end
         acc_nxt = 7'h00;
         iacc_nxt = 16'h0000;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_r <= '0;
         ext_r <= 1'b0;
         acc_r <= 7'h00;
         iacc_r <= 16'h0000;
         missed_r <= 1'b0;
         o_msg_strobe <= 1'b0;
         o_op_fault <= WORD_RESET;
         o_item_error <= WORD_RESET;
         o_slot_extended <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ext_r <= ext_nxt;
         acc_r <= acc_nxt;
         iacc_r <= iacc_nxt;
         missed_r <= missed_nxt;
         o_msg_strobe <= strobe_nxt & ~i_tx_busy;
         o_op_fault <= op_nxt;
         o_item_error <= ie_nxt;
         o_slot_extended <= ext_nxt;
      end
   end

   // clamped samples registered for the output message
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int k = 0; k < 6; k++) begin
            o_clamped[k] <= '0;
         end
      end else begin
         o_clamped <= clamped_c;
      end
   end

   // assertions
   a_spare_bits_zero: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      o_op_fault[15:7] == 9'h000) else $error("spare fault bits set");
   a_regulator_flag: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (strobe_nxt && !i_tx_busy && reg_bad) |=> o_op_fault[0])
      else $error("regulator fault not reported");
   a_slot_widens: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      ovr |=> o_slot_extended) else $error("slot not extended");
   a_clamp_flag: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (strobe_nxt && !i_tx_busy && flt.any_clamp) |=> o_op_fault[5])
      else $error("clamp not flagged");
   a_missed_flag: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (strobe_nxt && i_tx_busy) |=> missed_r) else $error("miss not held");
   a_no_latch: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (strobe_nxt && !i_tx_busy && (acc_r | word_bits) == 7'h00 && !missed_r)
      |=> o_op_fault == 16'h0000) else $error("fault word latched");
   a_item_clear: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (strobe_nxt && !i_tx_busy && (iacc_r | item_bits) == 16'h0000)
      |=> o_item_error == 16'h0000) else $error("item error latched");
   // a dropped message is owed to the host: the next sent word carries it
   sequence s_send_owed;
      strobe_nxt && !i_tx_busy && missed_r;
   endsequence
   a_missed_report: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      s_send_owed |=> o_op_fault[OF_MSG_MISSED]) else $error("miss not reported");
   a_periph_flag: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (strobe_nxt && !i_tx_busy && ptmo) |=> o_op_fault[3])
      else $error("timeout not flagged");
   a_combo_flag: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (strobe_nxt && !i_tx_busy && (|c2_r)) |=> o_op_fault[4])
      else $error("sensor fault not flagged");
   a_clamp_items: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      (strobe_nxt && !i_tx_busy) |=> ((o_item_error & $past(flt.clamp_mask))
      == $past(flt.clamp_mask))) else $error("clamped item not marked");
endmodule

// *** include/bit_flags_pkg.sv ***
// Purpose: shared constants for the built-in-test status word generator
// Assumes: 125 MHz clock, one message period marked by a one-cycle pulse
// Notes: bit positions of the operation fault word and item error word
package bit_flags_pkg;
   localparam int WORD_W = 16;
   localparam int ITEM_N = 16;
   // operation fault bit positions
   localparam int OF_REG_RANGE = 0;
   localparam int OF_SLOT_EXT = 1;
   localparam int OF_MSG_MISSED = 2;
   localparam int OF_PERIPH_TMO = 3;
   localparam int OF_COMBO_FAULT = 4;
   localparam int OF_CLAMPED = 5;
   localparam int OF_IMPLAUSIBLE = 6;
   // reset values
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // message period divider: normal and extended-slot counts (cycles)
   localparam int PERIOD_NORMAL = 1250;
   localparam int PERIOD_EXTENDED = 2500;
   localparam int CNT_W = 16;
   // clamp limits: rate in units of 1/16 deg/s, acceleration in mg
   localparam int RATE_LIMIT_DPS = 305;
   localparam int ACC_LIMIT_MG = 10010;
   localparam int RATE_LIMIT_CODE = RATE_LIMIT_DPS * 16;
   localparam int SAMPLE_W = 18;
endpackage

// *** include/fault_collect_if.sv ***
// Purpose: carries per-item fault attribution between collector and top
// Assumes: single clock domain
// Notes: masks are one bit per message item 2..17
`timescale 1ns/1ps
interface fault_collect_if;
   logic [15:0] clamp_mask;
   logic [15:0] implaus_mask;
   logic any_clamp;
   logic any_implaus;
   modport src (output clamp_mask, implaus_mask, any_clamp, any_implaus);
   modport dst (input clamp_mask, implaus_mask, any_clamp, any_implaus);
endinterface

// *** rtl/sample_checker.sv ***
// Purpose: clamps six samples and checks redundant accelerometer pairs
// Assumes: samples signed, rates in 1/16 deg/s, accelerations in mg
// Notes: combinational; results are registered by the top module
`timescale 1ns/1ps
module sample_checker
   import bit_flags_pkg::*;
#(
   parameter int PLAUS_TOL = 200
) (
   // raw samples: x rate, x acc, y rate, y acc, z rate, z acc
   input wire logic signed [SAMPLE_W-1:0] i_samp [6],
   // second accelerometer per axis (x, y, z)
   input wire logic signed [SAMPLE_W-1:0] i_acc_b [3],
   // clamped samples
   output logic signed [SAMPLE_W-1:0] o_clamped [6],
   // fault attribution
   fault_collect_if.src flt
);
   localparam logic signed [SAMPLE_W-1:0] RLIM = SAMPLE_W'(RATE_LIMIT_CODE);
   localparam logic signed [SAMPLE_W-1:0] ALIM = SAMPLE_W'(ACC_LIMIT_MG);
   logic [5:0] clip;
   logic [2:0] bad;

   // clamp each output to its range
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_clamp
         localparam logic signed [SAMPLE_W-1:0] LIM = (g % 2 == 0) ? RLIM : ALIM;
         // continuous assigns keep each bit of the shared vectors single-driven
         assign clip[g] = (i_samp[g] > LIM) || (i_samp[g] < -LIM);
         assign o_clamped[g] = (i_samp[g] > LIM) ? LIM
            : ((i_samp[g] < -LIM) ? -LIM : i_samp[g]);
      end
      // only accelerometers have a redundant partner on the same axis
      for (g = 0; g < 3; g++) begin : g_plaus
         logic signed [SAMPLE_W:0] diff;
         assign diff = {i_samp[2*g+1][SAMPLE_W-1], i_samp[2*g+1]}
            - {i_acc_b[g][SAMPLE_W-1], i_acc_b[g]};
         assign bad[g] = (diff > (SAMPLE_W+1)'(PLAUS_TOL))
            || (diff < -(SAMPLE_W+1)'(PLAUS_TOL));
      end
   endgenerate

   // items 2..7 map to mask bits 0..5
   always_comb begin
      flt.clamp_mask = {10'h000, clip};
      flt.implaus_mask = {10'h000, bad[2], 1'b0, bad[1], 1'b0, bad[0], 1'b0};
      flt.any_clamp = |clip;
      flt.any_implaus = |bad;
   end
endmodule

// *** test/host_rx.sv ***
// Purpose: host model that captures the status words of every message
// Assumes: words are valid in the strobe cycle only
// Notes: keeps the gap between messages in cycles for rate checks
`timescale 1ns/1ps
module host_rx (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // message stream
   input wire logic i_msg_strobe,
   input wire logic [15:0] i_op_fault,
   input wire logic [15:0] i_item_error,
   // captured words and timing
   output logic [15:0] o_op_seen,
   output logic [15:0] o_item_seen,
   output int o_count,
   output int o_gap
);
   int since_r;
   // whole 16-bit words are kept so spare bits stay visible to the bench
   always @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_op_seen <= 16'h0000;
         o_item_seen <= 16'h0000;
         o_count <= 0;
         o_gap <= 0;
         since_r <= 0;
      end else if (i_msg_strobe) begin
         o_op_seen <= i_op_fault;
         o_item_seen <= i_item_error;
         o_count <= o_count + 1;
         o_gap <= since_r;
         since_r <= 1;
      end else begin
         since_r <= since_r + 1;
      end
   end
endmodule

// *** test/bit_flags_tb.sv ***
// Purpose: self-checking bench for the status word generator
// Assumes: short message periods of 20 and 40 cycles
// Notes: each fault is held two periods so one whole period sees it
`timescale 1ns/1ps
module bit_flags_tb;
   import bit_flags_pkg::*;
   localparam int PN = 20;
   localparam int PE = 40;
   logic i_mclk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_reg_out_of_range = 1'b0;
   logic i_slot_overrun = 1'b0;
   logic i_periph_timeout = 1'b0;
   logic [15:0] i_periph_items = 16'h0000;
   logic [31:0] i_combo_sensor_runtime_fault [3] = '{default: 32'h0};
   logic [15:0] i_combo_items = 16'h0000;
   logic i_tx_busy = 1'b0;
   logic signed [SAMPLE_W-1:0] i_samp [6] = '{default: 18'h0};
   logic signed [SAMPLE_W-1:0] i_acc_b [3] = '{default: 18'h0};
   logic o_msg_strobe, o_slot_extended;
   logic [WORD_W-1:0] o_op_fault, o_item_error;
   logic signed [SAMPLE_W-1:0] o_clamped [6];
   logic [15:0] op_seen, item_seen;
   int count, gap, c0;
   int miscompares = 0;
   int checks_done = 0;
   always #4 i_mclk = ~i_mclk;
   bit_flags #(.P_NORMAL(PN), .P_EXT(PE)) DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .i_reg_out_of_range(i_reg_out_of_range), .i_slot_overrun(i_slot_overrun),
      .i_periph_timeout(i_periph_timeout), .i_periph_items(i_periph_items),
      .i_combo_sensor_runtime_fault(i_combo_sensor_runtime_fault),
      .i_combo_items(i_combo_items), .i_tx_busy(i_tx_busy), .i_samp(i_samp),
      .i_acc_b(i_acc_b), .o_msg_strobe(o_msg_strobe), .o_op_fault(o_op_fault),
      .o_item_error(o_item_error), .o_slot_extended(o_slot_extended),
      .o_clamped(o_clamped));
   host_rx host (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_msg_strobe(o_msg_strobe),
      .i_op_fault(o_op_fault), .i_item_error(o_item_error), .o_op_seen(op_seen),
      .o_item_seen(item_seen), .o_count(count), .o_gap(gap));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bounded wait for n more messages; a hang ends the run as a mismatch
   task automatic wait_msgs(input int n);
      int start;
      int k;
      start = count;
      for (k = 0; k < 400 && count < start + n; k++) begin
         @(posedge i_mclk);
         #1;
      end
      if (count < start + n) begin
         miscompares++;
         stop_test();
      end
   endtask
   task automatic expect_msg(input string name, input logic [15:0] op, input logic [15:0] it);
      wait_msgs(2);
      check(op_seen, op);
      check(item_seen, it);
      $display("test %0s done", name);
   endtask
   initial begin
      repeat (5) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      expect_msg("quiet", 16'h0000, 16'h0000);
      @(posedge i_mclk) i_reg_out_of_range <= 1'b1;
      expect_msg("regulator", 16'h0001, 16'h0000);
      @(posedge i_mclk) i_reg_out_of_range <= 1'b0;
      i_periph_timeout <= 1'b1;
      i_periph_items <= 16'hc001;
      expect_msg("timeout", 16'h0008, 16'hc001);
      @(posedge i_mclk) i_periph_timeout <= 1'b0;
      i_combo_sensor_runtime_fault[1] <= 32'h0000_0100;
      i_combo_items <= 16'h0030;
      expect_msg("sensor", 16'h0010, 16'h0030);
      @(posedge i_mclk) i_combo_sensor_runtime_fault[1] <= 32'h0;
      i_samp[0] <= 18'sd6000;
      i_samp[2] <= -18'sd6000;
      expect_msg("clamp", 16'h0020, 16'h0005);
      check(32'(o_clamped[0]), 32'(RATE_LIMIT_CODE));
      check(32'(o_clamped[2]), 32'(-RATE_LIMIT_CODE));
      @(posedge i_mclk) i_samp[0] <= 18'sd0;
      i_samp[2] <= 18'sd0;
      i_samp[3] <= 18'sd1000;
      expect_msg("plausibility", 16'h0040, 16'h0008);
      @(posedge i_mclk) i_samp[3] <= 18'sd0;
      expect_msg("plausible", 16'h0000, 16'h0000);
      // busy transmitter across one period end drops that message
      wait_msgs(1);
      @(posedge i_mclk) i_tx_busy <= 1'b1;
      c0 = count;
      repeat (30) @(posedge i_mclk);
      i_tx_busy <= 1'b0;
      check(count, c0);
      wait_msgs(1);
      check(op_seen, 16'h0004);
      @(posedge i_mclk) i_slot_overrun <= 1'b1;
      expect_msg("overrun", 16'h0002, 16'h0000);
      wait_msgs(1);
      check(32'(o_slot_extended), 32'h1);
      check(gap, PE);
      @(posedge i_mclk) i_slot_overrun <= 1'b0;
      expect_msg("normal rate", 16'h0000, 16'h0000);
      wait_msgs(1);
      check(32'(o_slot_extended), 32'h0);
      check(gap, PN);
      stop_test();
   end
endmodule
